// >>> rtl/tmr_capture_compare.v
// 16-bit timer/counter with prescaler, external clock, input capture,
// three compare channels and shared high-byte counter access.
// Assumes an AHB-Lite master with this block as the only slave, and pins
// already synchronous to clock_i.
//
// Operation
// RL1: Filter on: filtered capture changes only after four equal samples.
// RL2: Filter on: capture events are delayed by four clock cycles.
// RL3: Edge select zero triggers on falling edge, one on rising edge.
// RL4: Capture trigger copies counter into capture register and sets capture flag.
// RL5: In capture-register-top modes the capture pin is ignored entirely.
// RL6: Software writes zero to control B bit 5.
// RL7: Clock select 000 stops, 001 undivided, 010-101 divide by 8/64/256/1024.
// RL8: Clock select 110 counts external falling edges, 111 rising edges.
// RL9: External pin edges count even when that pin is driven as output.
// RL10: Force strobes act only in non-PWM waveform modes.
// RL11: Force strobe applies immediate match action per compare output mode.
// RL12: Force strobe sets no flag and never clears the counter.
// RL13: Force bits read back as zero.
// RL14: Software writes zero to control C bits 4 to 0.
// RL15: Counter accessed through two byte locations with shared temporary high byte.
// RL16: Counter write suppresses compare match on next timer tick, all channels.
// RL17: Control B: filter bit 7, edge bit 6, mode high 4:3, clock 2:0.
// RL18: Control C: force strobes A, B, C in bits 7, 6, 5.
// RL19: Software should avoid writing a running counter; matches may be missed.
// RL20: Waveform mode joins control B high bits with control A low bits.
// RL21: Modes 8, 10, 12 and 14 use capture register as top.
// RL22: Clock select 000 holds counter and raises no counting events.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`include "tmr_regs.vh"

module tmr_capture_compare (
    // Clock and reset
    input wire clock_i,
    input wire rst_i,
    // AHB-Lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [31:0] hrdata_o,
    // Timer pins
    input wire capture_pin_i,
    input wire external_clock_pin_i,
    output wire compare_output_a_o,
    output wire compare_output_b_o,
    output wire compare_output_c_o
);

    function is_fast;
        input [3:0] m;
        begin
            is_fast = (m == 4'h5) || (m == 4'h6) || (m == 4'h7) || (m == 4'he) || (m == 4'hf);
        end
    endfunction

    function is_dual;
        input [3:0] m;
        begin
            is_dual = (m == 4'h1) || (m == 4'h2) || (m == 4'h3) || (m[3:2] == 2'b10);
        end
    endfunction

    function is_pwm;
        input [3:0] m;
        begin
            is_pwm = is_fast(m) || is_dual(m);
        end
    endfunction

    // Capture register serves as top
    function icr_top;
        input [3:0] m;
        begin
            icr_top = m[3] & ~m[0]; // RL21
        end
    endfunction

    // Compare output mode field of one channel
    function [1:0] com_field;
        input [7:0] ctrl;
        input integer idx;
        begin
            case (idx)
                0: com_field = ctrl[`TMR_A_COM_A];
                1: com_field = ctrl[`TMR_A_COM_B];
                default: com_field = ctrl[`TMR_A_COM_C];
            endcase
        end
    endfunction

    // Register state
    reg [7:0] ctrl_a_reg;
    reg [7:0] ctrl_b_reg;
    reg [15:0] count_reg;
    reg [7:0] temp_reg;
    reg [15:0] cmp_reg [0:2];
    reg [15:0] capture_reg;
    reg [5:0] flags_reg;
    wire [2:0] oc_level;
    reg count_up_reg;
    reg block_reg;
    reg [9:0] pre_reg;
    reg ext_reg;
    reg ext_prev_reg;
    reg [`TMR_FILTER_SAMPLES-1:0] cap_hist_reg;
    reg cap_filt_reg;
    reg cap_prev_reg;

    // Bus state
    reg [7:0] addr_reg;
    reg wr_pend_reg;
    reg rd_pend_reg;

    wire [3:0] mode = {ctrl_b_reg[`TMR_B_WGM_HI], ctrl_a_reg[`TMR_A_WGM_LO]}; // RL20
    wire [2:0] clock_select = ctrl_b_reg[`TMR_B_CS];

    wire accept = hsel_i & htrans_i[1] & hready_i;
    wire wr_now = wr_pend_reg;
    wire wr_ctrl_c = wr_now && (addr_reg == `TMR_OFF_CTRL_C);
    wire wr_count_lo = wr_now && (addr_reg == `TMR_OFF_COUNT_LO);
    wire wr_count_hi = wr_now && (addr_reg == `TMR_OFF_COUNT_HI);
    wire rd_count_lo = rd_pend_reg && (addr_reg == `TMR_OFF_COUNT_LO);

    // Force strobes exist only for the write cycle
    wire [2:0] force_strobe = wr_ctrl_c ? {hwdata_i[`TMR_C_FORCE_C], hwdata_i[`TMR_C_FORCE_B],
        hwdata_i[`TMR_C_FORCE_A]} : 3'h0; // RL18

    // Timer tick selection
    reg tick;
    always @* begin
        case (clock_select)
            `TMR_CS_STOP: tick = 1'b0; // RL7 RL22
            `TMR_CS_DIV1: tick = 1'b1; // RL7
            // Prescaler runs free, so the first divided tick may come early
            `TMR_CS_DIV8: tick = &pre_reg[2:0]; // RL7
            `TMR_CS_DIV64: tick = &pre_reg[5:0]; // RL7
            `TMR_CS_DIV256: tick = &pre_reg[7:0]; // RL7
            `TMR_CS_DIV1024: tick = &pre_reg[9:0]; // RL7
            // Pin sampled regardless of its port direction
            `TMR_CS_EXT_FALL: tick = ext_prev_reg & ~ext_reg; // RL8 RL9
            default: tick = ~ext_prev_reg & ext_reg; // RL8 RL9
        endcase
    end

    // Top value per waveform mode
    reg [15:0] top;
    always @* begin
        case (mode)
            4'h1, 4'h5: top = 16'h00ff;
            4'h2, 4'h6: top = 16'h01ff;
            4'h3, 4'h7: top = 16'h03ff;
            4'h4, 4'h9, 4'hb, 4'hf: top = cmp_reg[0];
            4'h8, 4'ha, 4'hc, 4'he: top = capture_reg;
            default: top = 16'hffff;
        endcase
    end

    wire at_top = count_reg == top;
    wire at_bottom = count_reg == 16'h0000;
    wire dual = is_dual(mode);
    wire pwm = is_pwm(mode);

    // Capture path: unfiltered uses newest sample, filtered waits for agreement
    wire cap_level = ctrl_b_reg[`TMR_B_FILTER] ? cap_filt_reg : cap_hist_reg[0];
    wire cap_rise = cap_level & ~cap_prev_reg;
    wire cap_fall = ~cap_level & cap_prev_reg;
    wire cap_edge = ctrl_b_reg[`TMR_B_EDGE] ? cap_rise : cap_fall; // RL3
    wire cap_event = cap_edge & ~icr_top(mode); // RL5

    // Compare matches, removed on the tick after a counter write
    wire [2:0] match;
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_match
            assign match[ch] = tick & ~block_reg & (count_reg == cmp_reg[ch]); // RL16
        end
    endgenerate

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg <= 10'h000;
            ext_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            cap_hist_reg <= {`TMR_FILTER_SAMPLES{1'b0}};
            cap_filt_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
        end else begin
            pre_reg <= pre_reg + 10'h001;
            ext_reg <= external_clock_pin_i;
            ext_prev_reg <= ext_reg;
            cap_hist_reg <= {cap_hist_reg[`TMR_FILTER_SAMPLES-2:0], capture_pin_i};
            if (&cap_hist_reg || ~|cap_hist_reg) begin
                cap_filt_reg <= cap_hist_reg[`TMR_FILTER_SAMPLES-1]; // RL1 RL2
            end
            cap_prev_reg <= cap_level;
        end
    end

    // Counter, capture and flags
    reg [5:0] flag_set;
    always @* begin
        flag_set = 6'h00;
        flag_set[`TMR_F_CAPTURE] = cap_event | (tick & at_top & icr_top(mode)); // RL4
        // Only real matches reach the flags, never force strobes
        flag_set[`TMR_F_CMP_A] = match[0]; // RL12
        flag_set[`TMR_F_CMP_B] = match[1];
        flag_set[`TMR_F_CMP_C] = match[2];
        flag_set[`TMR_F_OVERFLOW] = tick & (dual ? (at_bottom & ~count_up_reg) : at_top);
    end

    wire [5:0] flag_clr = (wr_now && addr_reg == `TMR_OFF_FLAGS) ? hwdata_i[5:0] : 6'h00;

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= `TMR_WORD_RST;
            count_up_reg <= 1'b1;
            block_reg <= 1'b0;
            capture_reg <= `TMR_WORD_RST;
            flags_reg <= `TMR_FLAGS_RST;
        end else begin
            // Set beats a same-cycle write-one clear
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
            if (cap_event) begin
                capture_reg <= count_reg; // RL4
            end
            // Counter write wins over a same-cycle tick
            if (wr_count_lo) begin
                count_reg <= {temp_reg, hwdata_i[7:0]}; // RL15
                block_reg <= 1'b1; // RL16
            end else if (tick) begin
                block_reg <= 1'b0;
                if (dual) begin
                    if (count_up_reg && at_top) begin
                        count_up_reg <= 1'b0;
                        count_reg <= count_reg - 16'h0001;
                    end else if (!count_up_reg && at_bottom) begin
                        count_up_reg <= 1'b1;
                        count_reg <= count_reg + 16'h0001;
                    end else if (count_up_reg) begin
                        count_reg <= count_reg + 16'h0001;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end else begin
                    count_up_reg <= 1'b1;
                    count_reg <= at_top ? 16'h0000 : count_reg + 16'h0001;
                end
            end
        end
    end

    // Compare output units
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_out
            wire [1:0] com = com_field(ctrl_a_reg, ch);
            wire forced = force_strobe[ch] & ~pwm; // RL10
            wire toggle_ok = (ch == 0) && (mode == 4'he || mode == 4'hf ||
                mode[3:2] == 2'b10);
            // One flop per channel keeps a single driver on each output bit
            reg out_reg;
            assign oc_level[ch] = out_reg;
            always @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    out_reg <= 1'b0;
                end else if (forced || (match[ch] && !pwm)) begin
                    // Force only drives the pin; counter is untouched
                    case (com)
                        2'b01: out_reg <= ~out_reg; // RL11
                        2'b10: out_reg <= 1'b0; // RL11
                        2'b11: out_reg <= 1'b1; // RL11
                        default: out_reg <= out_reg;
                    endcase
                end else if (pwm && com == 2'b01) begin
                    if (match[ch] && toggle_ok) begin
                        out_reg <= ~out_reg;
                    end
                end else if (pwm && com[1]) begin
                    if (match[ch]) begin
                        out_reg <= (dual && !count_up_reg) ? ~com[0] : com[0];
                    end else if (tick && at_top && !dual) begin
                        out_reg <= ~com[0];
                    end
                end
            end
        end
    endgenerate

    assign compare_output_a_o = oc_level[0];
    assign compare_output_b_o = oc_level[1];
    assign compare_output_c_o = oc_level[2];

    // Control, compare and temporary byte writes
    integer i;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_a_reg <= `TMR_CTRL_RST;
            ctrl_b_reg <= `TMR_CTRL_RST;
            temp_reg <= 8'h00;
            for (i = 0; i < 3; i = i + 1) begin
                cmp_reg[i] <= `TMR_WORD_RST;
            end
        end else begin
            if (wr_now) begin
                case (addr_reg)
                    `TMR_OFF_CTRL_A: ctrl_a_reg <= hwdata_i[7:0];
                    // Reserved bit 5 is not stored
                    `TMR_OFF_CTRL_B: ctrl_b_reg <= hwdata_i[7:0] & 8'hdf; // RL17 RL6
                    `TMR_OFF_CMP_A: cmp_reg[0] <= hwdata_i[15:0];
                    `TMR_OFF_CMP_B: cmp_reg[1] <= hwdata_i[15:0];
                    `TMR_OFF_CMP_C: cmp_reg[2] <= hwdata_i[15:0];
                    default: ;
                endcase
            end
            if (wr_count_hi) begin
                temp_reg <= hwdata_i[7:0]; // RL15
            end else if (rd_count_lo) begin
                temp_reg <= count_reg[15:8]; // RL15
            end
        end
    end

    // Read mux, evaluated in the wait cycle of a read
    reg [31:0] rd_val;
    always @* begin
        case (addr_reg)
            `TMR_OFF_CTRL_A: rd_val = {24'h000000, ctrl_a_reg};
            `TMR_OFF_CTRL_B: rd_val = {24'h000000, ctrl_b_reg};
            `TMR_OFF_CTRL_C: rd_val = 32'h00000000; // RL13 RL14
            `TMR_OFF_COUNT_LO: rd_val = {24'h000000, count_reg[7:0]};
            `TMR_OFF_COUNT_HI: rd_val = {24'h000000, temp_reg}; // RL15
            `TMR_OFF_CMP_A: rd_val = {16'h0000, cmp_reg[0]};
            `TMR_OFF_CMP_B: rd_val = {16'h0000, cmp_reg[1]};
            `TMR_OFF_CMP_C: rd_val = {16'h0000, cmp_reg[2]};
            `TMR_OFF_CAPTURE: rd_val = {16'h0000, capture_reg};
            `TMR_OFF_FLAGS: rd_val = {26'h0, flags_reg & 6'h2f};
            default: rd_val = 32'h00000000;
        endcase
    end

    // AHB-Lite handshake: writes zero-wait, reads one wait state so a
    // preceding write has landed before the read value is taken
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            addr_reg <= 8'h00;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h00000000;
        end else begin
            hresp_o <= 1'b0;
            if (rd_pend_reg) begin
                hrdata_o <= rd_val;
                rd_pend_reg <= 1'b0;
                hreadyout_o <= 1'b1;
            end
            if (accept) begin
                addr_reg <= {haddr_i[7:2], 2'b00};
                wr_pend_reg <= hwrite_i;
                rd_pend_reg <= ~hwrite_i;
                hreadyout_o <= hwrite_i;
            end else if (hready_i) begin
                wr_pend_reg <= 1'b0;
            end
        end
    end

endmodule

// >>> include/tmr_regs.vh
// Register map, field positions and reset values of the 16-bit timer block.
// Included by the timer RTL; definitions only.
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// Byte offsets on the register bus, one aligned word each
`define TMR_OFF_CTRL_A 8'h00
`define TMR_OFF_CTRL_B 8'h04
`define TMR_OFF_CTRL_C 8'h08
`define TMR_OFF_COUNT_LO 8'h0c
`define TMR_OFF_COUNT_HI 8'h10
`define TMR_OFF_CMP_A 8'h14
`define TMR_OFF_CMP_B 8'h18
`define TMR_OFF_CMP_C 8'h1c
`define TMR_OFF_CAPTURE 8'h20
`define TMR_OFF_FLAGS 8'h24

// Control register A fields
`define TMR_A_COM_A 7:6
`define TMR_A_COM_B 5:4
`define TMR_A_COM_C 3:2
`define TMR_A_WGM_LO 1:0

// Control register B fields
`define TMR_B_FILTER 7
`define TMR_B_EDGE 6
`define TMR_B_WGM_HI 4:3
`define TMR_B_CS 2:0

// Control register C force strobes
`define TMR_C_FORCE_A 7
`define TMR_C_FORCE_B 6
`define TMR_C_FORCE_C 5

// Flag register bits
`define TMR_F_CAPTURE 5
`define TMR_F_CMP_C 3
`define TMR_F_CMP_B 2
`define TMR_F_CMP_A 1
`define TMR_F_OVERFLOW 0

// Clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7

// Reset values
`define TMR_CTRL_RST 8'h00
`define TMR_WORD_RST 16'h0000
`define TMR_FLAGS_RST 6'h00

// Capture filter length in samples
`define TMR_FILTER_SAMPLES 4

`endif

// >>> verif/tmr_capture_compare_monitor.sv
// Port-level checker for the timer register block.
// Assumes hready_i is hreadyout_o fed back and whole-word single transfers.
module tmr_capture_compare_monitor (
    // Clock and reset
    input wire clock_i,
    input wire rst_i,
    // Bus
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire [31:0] hrdata_o,
    // Pins
    input wire compare_output_a_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    wire rd_w = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    wire wr_w = hsel_i && htrans_i[1] && hready_i && hwrite_i;
    reg aph_reg;
    reg [5:0] adr_reg;
    reg [7:0] ctla_reg;
    reg [7:0] ctlb_reg;
    reg [2:0] frc_reg;
    wire [3:0] mode_w = {ctlb_reg[4:3], ctla_reg[1:0]};
    wire npwm_w = mode_w == 4'h0 || mode_w == 4'h4 || mode_w == 4'hc;
    wire stop_w = ctlb_reg[2:0] == 3'h0;
    // Shadow of written control bytes, taken at each write data edge
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            aph_reg <= 1'b0;
            adr_reg <= 6'h0;
            ctla_reg <= 8'h00;
            ctlb_reg <= 8'h00;
            frc_reg <= 3'h0;
        end else begin
            aph_reg <= wr_w;
            adr_reg <= haddr_i[7:2];
            frc_reg <= (aph_reg && adr_reg == 6'h02) ? hwdata_i[7:5] : 3'h0;
            if (aph_reg && adr_reg == 6'h00) begin
                ctla_reg <= hwdata_i[7:0];
            end
            if (aph_reg && adr_reg == 6'h01) begin
                ctlb_reg <= hwdata_i[7:0];
            end
        end
    end
    AST_READ_WAIT: assert property (rd_w |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait cycle wrong");
    AST_WRITE_NOWAIT: assert property (wr_w |=> hreadyout_o)
        else $error("write stalled");
    AST_RDATA_HOLD: assert property ($changed(hrdata_o) |-> $past(rd_w, 2))
        else $error("read data moved without a read");
    AST_FORCE_READS_ZERO: assert property (rd_w && haddr_i[7:2] == 6'h02 |-> ##2 hrdata_o == 32'h0)
        else $error("control C read not zero");
    AST_CTRLB_READ: assert property (rd_w && haddr_i[7:2] == 6'h01
        |-> ##2 hrdata_o == {24'h0, ctlb_reg & 8'hdf})
        else $error("control B read back wrong");
    AST_STOP_HOLD: assert property (stop_w && $past(stop_w) && frc_reg == 3'h0
        |-> $stable(compare_output_a_o))
        else $error("output moved while stopped");
    AST_FORCE_PWM: assert property (frc_reg != 3'h0 && !npwm_w && stop_w
        |-> $stable(compare_output_a_o))
        else $error("force acted in a PWM mode");
    AST_FORCE_ACT: assert property (frc_reg[2] && npwm_w && stop_w && ctla_reg[7:6] != 2'b00
        |-> compare_output_a_o == (ctla_reg[7] ? ctla_reg[6] : !$past(compare_output_a_o)))
        else $error("forced match action wrong");
    cover property (frc_reg[2] && npwm_w);
    cover property (frc_reg[2] && !npwm_w);
    cover property (rd_w && haddr_i[7:2] == 6'h08);
endmodule

// >>> verif/tmr_pin_model.sv
// Outside driver of the capture pin and the external count pin.
// Assumes tasks are entered just after a rising edge of clock_i.
module tmr_pin_model (
    // Clock
    input wire clock_i,
    // Pins toward the block
    output logic capture_pin_o,
    output logic external_clock_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        capture_pin_o = 1'b0;
        external_clock_pin_o = 1'b0;
    end
    task automatic cap_drive(input logic lvl, input int hold);
        capture_pin_o <= lvl;
        repeat (hold) @(posedge clock_i);
    endtask
    // Wider half periods model a slow outside source
    task automatic ext_pulse(input int n, input int half, input logic tail);
        repeat (n) begin
            external_clock_pin_o <= 1'b1;
            repeat (half) @(posedge clock_i);
            external_clock_pin_o <= 1'b0;
            repeat (half) @(posedge clock_i);
        end
        external_clock_pin_o <= tail;
        repeat (half) @(posedge clock_i);
    endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the timer block, registers over AHB-Lite.
// Assumes a single slave with hready fed back and the pin model outside.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    wire hreadyout_o;
    wire [31:0] hrdata_o;
    wire cap_w;
    wire ext_w;
    wire hresp_w;
    wire [2:0] oc_w;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] rd_v;
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;
    tmr_capture_compare tmr_capture_compare_inst (.clock_i(clock_i), .rst_i(rst_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_w), .hrdata_o(hrdata_o),
        .capture_pin_i(cap_w), .external_clock_pin_i(ext_w),
        .compare_output_a_o(oc_w[0]), .compare_output_b_o(oc_w[1]),
        .compare_output_c_o(oc_w[2]));
    tmr_pin_model tmr_pin_model_inst (.clock_i(clock_i), .capture_pin_o(cap_w),
        .external_clock_pin_o(ext_w));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_rdy();
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {24'h0, a};
        wait_rdy();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_rdy();
        rd_v = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd_v, exp);
    endtask
    // High byte first so the low write moves the whole word
    task automatic cnt_wr(input logic [15:0] v);
        wr(8'h10, {24'h0, v[15:8]});
        wr(8'h0c, {24'h0, v[7:0]});
    endtask
    task automatic cnt_get(output logic [15:0] r);
        bus(1'b0, 8'h0c, 32'h0);
        r[7:0] = rd_v[7:0];
        bus(1'b0, 8'h10, 32'h0);
        r[15:8] = rd_v[7:0];
    endtask
    function automatic int div_of(input int code);
        return code == 1 ? 1 : code == 2 ? 8 : code == 3 ? 64 : code == 4 ? 256 : 1024;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock_i);
        fail_count++;
        end_of_test();
    end
    initial begin
        logic [15:0] v;
        logic [15:0] g;
        logic [15:0] c0;
        logic o_exp;
        int t0;
        int k;
        void'($urandom(82));
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        for (int a = 0; a < 11; a++) chk("reset", 8'(a * 4), 32'h0);
        wr(8'h28, 32'hffffffff);
        chk("unmapped", 8'h28, 32'h0);
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom);
            wr(8'h14 + 8'(i * 4), {16'h0, v});
            chk("compare", 8'h14 + 8'(i * 4), {16'h0, v});
        end
        wr(8'h04, 32'hff);
        chk("ctrl_b", 8'h04, 32'hdf);
        $display("registers done");
        wr(8'h04, 32'h08);
        v = 16'($urandom);
        cnt_wr(v);
        o_exp = 1'b0;
        for (int c = 1; c < 4; c++) begin
            wr(8'h00, 32'(c * 8'h54));
            wr(8'h08, 32'he0);
            chk("force_rd", 8'h08, 32'h0);
            o_exp = (c == 1) ? !o_exp : (c == 3);
            check("force_out", {29'h0, oc_w}, {29'h0, {3{o_exp}}});
            chk("force_flag", 8'h24, 32'h0);
        end
        wr(8'h00, 32'h41);
        wr(8'h08, 32'he0);
        cnt_get(g);
        check("held_count", {16'h0, g}, {16'h0, v});
        check("pwm_force_out", {29'h0, oc_w}, 32'h7);
        wr(8'h00, 32'h0);
        $display("force done");
        for (int c = 1; c < 6; c++) begin
            cnt_wr(16'h0);
            wr(8'h04, 32'(c));
            t0 = cyc;
            repeat (4 * div_of(c)) @(posedge clock_i);
            wr(8'h04, 32'h0);
            k = (cyc - t0) / div_of(c);
            cnt_get(g);
            check("prescale", 32'(g + 1 >= k && g <= k + 1), 32'h1);
        end
        for (int c = 6; c < 8; c++) begin
            k = $urandom_range(6, 2);
            cnt_wr(16'h0);
            wr(8'h04, 32'(c));
            tmr_pin_model_inst.ext_pulse(k, 3 + 4 * (c - 6), 1'b1);
            repeat (6) @(posedge clock_i);
            wr(8'h04, 32'h0);
            cnt_get(g);
            check("ext_count", {16'h0, g}, 32'(k + c - 6));
            tmr_pin_model_inst.ext_pulse(0, 3, 1'b0);
        end
        $display("clock select done");
        for (int e = 0; e < 2; e++) begin
            v = 16'($urandom);
            cnt_wr(v);
            wr(8'h04, 32'(e << 6));
            tmr_pin_model_inst.cap_drive(e[0], 10);
            wr(8'h24, 32'h2f);
            tmr_pin_model_inst.cap_drive(!e[0], 10);
            chk("cap_wrong_edge", 8'h24, 32'h0);
            tmr_pin_model_inst.cap_drive(e[0], 10);
            chk("cap_flag", 8'h24, 32'h20);
            chk("cap_value", 8'h20, {16'h0, v});
            wr(8'h24, 32'h20);
        end
        wr(8'h04, 32'hc0);
        tmr_pin_model_inst.cap_drive(1'b0, 2);
        tmr_pin_model_inst.cap_drive(1'b1, 12);
        chk("glitch", 8'h24, 32'h0);
        for (int f = 0; f < 2; f++) begin
            wr(8'h04, {24'h0, f[0], 7'h41});
            tmr_pin_model_inst.cap_drive(1'b0, 12);
            wr(8'h24, 32'h20);
            cnt_wr(16'h0);
            tmr_pin_model_inst.cap_drive(1'b1, 12);
            bus(1'b0, 8'h20, 32'h0);
            if (f == 0) c0 = rd_v[15:0];
        end
        check("filter_delay", {16'h0, rd_v[15:0] - c0}, 32'h4);
        wr(8'h04, 32'h58);
        tmr_pin_model_inst.cap_drive(1'b0, 12);
        wr(8'h24, 32'h2f);
        tmr_pin_model_inst.cap_drive(1'b1, 12);
        chk("cap_top_mode", 8'h24, 32'h0);
        $display("capture done");
        wr(8'h04, 32'h07);
        v = 16'($urandom_range(16'hfff0, 16'h10));
        for (int i = 0; i < 3; i++) wr(8'h14 + 8'(i * 4), {16'h0, v});
        for (int o = 0; o < 3; o++) begin
            wr(8'h24, 32'h2f);
            cnt_wr(v - 16'(o == 2 ? 2 : o));
            tmr_pin_model_inst.ext_pulse(o == 2 ? 3 : 1, 3, 1'b0);
            repeat (6) @(posedge clock_i);
            chk("match_block", 8'h24, o == 2 ? 32'h0e : 32'h0);
        end
        check("hresp", {31'h0, hresp_w}, 32'h0);
        $display("block done");
        end_of_test();
    end
endmodule

bind tmr_capture_compare tmr_capture_compare_monitor tmr_capture_compare_monitor_inst (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .compare_output_a_o(compare_output_a_o));
